// ---- ccc_conv_model.sv ----
// converter front end: free-running converter clock and bitstream
// bit 1 charges, 0 discharges; shorted inputs carry a +1/2 offset per tick
`timescale 1ns/100ps
`default_nettype none
module ccc_conv_model
#(
	parameter HALF = 80
)
(
	// control
	input  wire logic short_en,
	input  wire logic level,
	// pins toward the block
	output var  logic conv_clk,
	output var  logic conv_bit
);
// converter clock, sped up for simulation
initial conv_clk = 1'b0;
always #HALF conv_clk = ~conv_clk;
// bit moves away from the sampling edge
logic [1:0] ph = 2'h0;
initial conv_bit = 1'b1;
// shorted: three charge bits in four, so every period reads half its length
always @(negedge conv_clk)
begin
	ph       <= ph + 2'h1;
	conv_bit <= short_en ? (ph != 2'h3) : level;
end
endmodule
`default_nettype wire

// ---- ccc_coulomb_ctrl.v ----
// coulomb counter control: integration timing, calibration, results
// assumes a 50 MHz clk, a 32.768 kHz converter clock and the analog
// modulator bitstream both arriving as asynchronous pins
//
// Operation
// - four integration periods 250, 62.5, 15.6, 3.9 ms; 250 ms at reset
// - next integration period starts at once when previous result lands
// - converter and periods are timed from the 32.768 kHz clock
// - longest period gives 13 magnitude bits plus sign, two's complement
// - current out of the battery reads negative, sign bit one
// - calibration shorts inputs, runs eight periods, keeps 10-bit offset
// - calibration end raises the calibration done interrupt
// - calibration request bit clears itself when calibration finishes
// - after calibration the gauge returns to normal measuring by itself
// - wipe clears offset, tally and sum, then reads back zero
// - hold blocks result, sum and tally updates; integrator keeps running
// - a period ending under hold is discarded; next period starts anyway
// - writing dither set turns converter dithering on
// - wipe leaves the dither state alone
// - dither clear turns dithering off; a status bit shows dither state
// - 14-bit last result holds the latest measurement finished outside hold and calibration
`timescale 1ns/100ps
`default_nettype none
`include "ccc_map.vh"

module ccc_coulomb_ctrl
#(
	parameter AW    = 8,
	parameter PER_W = 14
)
(
	// system
	input  wire          clk,
	input  wire          nrst,
	// wishbone slave
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [AW-1:0] wb_adr_i,
	input  wire [3:0]    wb_sel_i,
	input  wire [31:0]   wb_dat_i,
	output reg  [31:0]   wb_dat_o,
	output reg           wb_ack_o,
	// analog converter side
	input  wire          conv_clk_pin,
	input  wire          conv_bit_pin,
	output reg           conv_short_r,
	output reg           dither_active_r,
	// event
	output reg           calib_done_irq_r
);

	//--------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------
	// integer forms first, then cut to the counter widths on purpose
	localparam integer     LEN0_I     = `CCC_US_TO_TICKS(`CCC_PER0_US);
	localparam integer     LEN1_I     = `CCC_US_TO_TICKS(`CCC_PER1_US);
	localparam integer     LEN2_I     = `CCC_US_TO_TICKS(`CCC_PER2_US);
	localparam integer     LEN3_I     = `CCC_US_TO_TICKS(`CCC_PER3_US);
	localparam integer     CAL_LAST_I = `CCC_CAL_RUNS - 1;
	localparam [PER_W-1:0] LEN0       = LEN0_I[PER_W-1:0];
	localparam [PER_W-1:0] LEN1       = LEN1_I[PER_W-1:0];
	localparam [PER_W-1:0] LEN2       = LEN2_I[PER_W-1:0];
	localparam [PER_W-1:0] LEN3       = LEN3_I[PER_W-1:0];
	localparam [2:0]       CAL_LAST   = CAL_LAST_I[2:0];

	// period length in converter ticks for a selection code
	function [PER_W-1:0] period_len;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    period_len = LEN0;
				2'h1:    period_len = LEN1;
				2'h2:    period_len = LEN2;
				default: period_len = LEN3;
			endcase
		end
	endfunction

	// limit the raw up/down count to the 14-bit signed result range
	function [13:0] clamp14;
		input [14:0] raw;
		begin
			if (!raw[14] && raw[13])
				clamp14 = 14'h1FFF;
			else if (raw[14] && !raw[13])
				clamp14 = 14'h2000;
			else
				clamp14 = raw[13:0];
		end
	endfunction

	function [31:0] sext14;
		input [13:0] v;
		begin
			sext14 = {{18{v[13]}}, v};
		end
	endfunction

	//--------------------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------------------
	// third stage must agree with the second before a change counts
	reg  ck_s1_r;
	reg  ck_s2_r;
	reg  ck_s3_r;
	reg  ck_lvl_r;
	reg  bt_s1_r;
	reg  bt_s2_r;
	reg  bt_s3_r;
	reg  bt_lvl_r;
	wire ck_agree;
	wire conv_tick;

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ck_s1_r  <= 1'b0;
			ck_s2_r  <= 1'b0;
			ck_s3_r  <= 1'b0;
			ck_lvl_r <= 1'b0;
			bt_s1_r  <= 1'b0;
			bt_s2_r  <= 1'b0;
			bt_s3_r  <= 1'b0;
			bt_lvl_r <= 1'b0;
		end
		else
		begin
			ck_s1_r <= conv_clk_pin;
			ck_s2_r <= ck_s1_r;
			ck_s3_r <= ck_s2_r;
			bt_s1_r <= conv_bit_pin;
			bt_s2_r <= bt_s1_r;
			bt_s3_r <= bt_s2_r;
			if (ck_agree)
				ck_lvl_r <= ck_s3_r;
			if (bt_s2_r == bt_s3_r)
				bt_lvl_r <= bt_s3_r;
		end
	end

	assign ck_agree  = (ck_s2_r == ck_s3_r);
	assign conv_tick = ck_agree & ck_s3_r & ~ck_lvl_r;

	//--------------------------------------------------------------
	// wishbone register access
	//--------------------------------------------------------------
	reg              en_r;
	reg  [1:0]       psel_r;
	reg              hold_updates_r;
	reg              calib_request_r;
	reg              wipe_results_r;
	reg  [9:0]       calib_offset_value_r;
	reg  [23:0]      sample_tally_r;
	reg  [31:0]      charge_sum_r;
	reg  [13:0]      last_period_result_r;
	reg              cal_active_r;
	reg  [31:0]      rd_nxt;
	wire             wb_req;
	wire             ctrl_wr;
	wire             cal_finish;

	assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign ctrl_wr = wb_req & wb_we_i & wb_sel_i[0] &
	                 (wb_adr_i == `CCC_CTRL_OFS);

	// unmapped addresses read zero and ignore writes, still acked
	always @*
	begin
		rd_nxt = `CCC_ZERO32;
		case (wb_adr_i)
			`CCC_CTRL_OFS:
			begin
				rd_nxt[`CCC_EN_BIT]                    = en_r;
				rd_nxt[`CCC_PSEL_HI:`CCC_PSEL_LO]      = psel_r;
				rd_nxt[`CCC_HOLD_BIT]                  = hold_updates_r;
				rd_nxt[`CCC_CALREQ_BIT]                = calib_request_r;
				rd_nxt[`CCC_WIPE_BIT]                  = wipe_results_r;
				rd_nxt[`CCC_DACT_BIT]                  = dither_active_r;
				rd_nxt[`CCC_CALBUSY_BIT]               = cal_active_r;
			end
			`CCC_OFFSET_OFS: rd_nxt[9:0]  = calib_offset_value_r;
			`CCC_TALLY_OFS:  rd_nxt[23:0] = sample_tally_r;
			`CCC_SUM_OFS:    rd_nxt       = charge_sum_r;
			`CCC_LAST_OFS:   rd_nxt[13:0] = last_period_result_r;
			default:         rd_nxt       = `CCC_ZERO32;
		endcase
	end

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o        <= 1'b0;
			wb_dat_o        <= `CCC_ZERO32;
			en_r            <= 1'b0;
			psel_r          <= `CCC_PSEL_RST;
			hold_updates_r  <= 1'b0;
			calib_request_r <= 1'b0;
			wipe_results_r  <= 1'b0;
			dither_active_r <= 1'b0;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req)
				wb_dat_o <= rd_nxt;
			// wipe bit lasts a single cycle
			wipe_results_r <= ctrl_wr & wb_dat_i[`CCC_WIPE_BIT];
			if (ctrl_wr)
			begin
				en_r           <= wb_dat_i[`CCC_EN_BIT];
				// selection, applied at the next period start
				psel_r         <= wb_dat_i[`CCC_PSEL_HI:`CCC_PSEL_LO];
				hold_updates_r <= wb_dat_i[`CCC_HOLD_BIT];
			end
			// hardware clear, but a software set in the same cycle wins
			if (ctrl_wr && wb_dat_i[`CCC_CALREQ_BIT])
				calib_request_r <= 1'b1;
			else if (cal_finish)
				calib_request_r <= 1'b0;
			// set, clear; set takes priority if both written
			if (ctrl_wr && wb_dat_i[`CCC_DSET_BIT])
				dither_active_r <= 1'b1;
			else if (ctrl_wr && wb_dat_i[`CCC_DCLR_BIT])
				dither_active_r <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// integration period timing
	//--------------------------------------------------------------
	reg  [PER_W-1:0] per_cnt_r;
	reg  [PER_W-1:0] per_len_r;
	reg  [14:0]      integ_r;
	wire [14:0]      integ_step;
	wire             per_end;
	wire [13:0]      res_now;

	// a low bit is discharge and steps the count down
	assign integ_step = bt_lvl_r ? (integ_r + 15'h0001) :
	                               (integ_r - 15'h0001);
	assign per_end    = en_r & conv_tick & (per_cnt_r == per_len_r - 1'b1);
	assign res_now    = clamp14(integ_step);

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			per_cnt_r <= {PER_W{1'b0}};
			per_len_r <= LEN0;
			integ_r   <= 15'h0000;
		end
		else if (!en_r)
		begin
			per_cnt_r <= {PER_W{1'b0}};
			per_len_r <= period_len(psel_r);
			integ_r   <= 15'h0000;
		end
		else if (per_end)
		begin
			// next period starts on the same tick, no gap
			per_cnt_r <= {PER_W{1'b0}};
			per_len_r <= period_len(psel_r);
			integ_r   <= 15'h0000;
		end
		else if (conv_tick)
		begin
			// integrator runs whatever the hold bit says
			per_cnt_r <= per_cnt_r + 1'b1;
			integ_r   <= integ_step;
		end
	end

	//--------------------------------------------------------------
	// calibration sequence
	//--------------------------------------------------------------
	reg  [2:0]  cal_runs_r;
	reg  [17:0] cal_acc_r;
	wire [17:0] cal_acc_nxt;

	assign cal_acc_nxt = cal_acc_r + {{4{res_now[13]}}, res_now};
	assign cal_finish  = per_end & cal_active_r & (cal_runs_r == CAL_LAST);

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cal_active_r     <= 1'b0;
			conv_short_r     <= 1'b0;
			cal_runs_r       <= 3'h0;
			cal_acc_r        <= 18'h00000;
			calib_done_irq_r <= 1'b0;
		end
		else
		begin
			calib_done_irq_r <= cal_finish;
			if (!en_r)
			begin
				// dropping enable abandons a run in progress
				cal_active_r <= 1'b0;
				conv_short_r <= 1'b0;
			end
			else if (cal_finish)
			begin
				// back to normal measuring with no software step
				cal_active_r <= 1'b0;
				conv_short_r <= 1'b0;
			end
			else if (per_end && cal_active_r)
			begin
				cal_runs_r <= cal_runs_r + 3'h1;
				cal_acc_r  <= cal_acc_nxt;
			end
			else if (per_end && calib_request_r)
			begin
				// short the inputs from the next period boundary
				cal_active_r <= 1'b1;
				conv_short_r <= 1'b1;
				cal_runs_r   <= 3'h0;
				cal_acc_r    <= 18'h00000;
			end
		end
	end

	//--------------------------------------------------------------
	// result registers
	//--------------------------------------------------------------
	wire [17:0] cal_avg;
	wire        keep_result;

	assign cal_avg     = $signed(cal_acc_nxt) >>> `CCC_CAL_SHIFT;
	// held or calibration periods are dropped
	assign keep_result = per_end & ~cal_active_r & ~hold_updates_r;

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			calib_offset_value_r <= 10'h000;
			sample_tally_r       <= 24'h000000;
			charge_sum_r         <= `CCC_ZERO32;
			last_period_result_r <= 14'h0000;
		end
		else
		begin
			if (keep_result)
				last_period_result_r <= res_now;
			if (wipe_results_r)
			begin
				calib_offset_value_r <= 10'h000;
				sample_tally_r       <= 24'h000000;
				charge_sum_r         <= `CCC_ZERO32;
			end
			else
			begin
				// offset kept as 10-bit signed value
				if (cal_finish)
					calib_offset_value_r <= cal_avg[9:0];
				if (keep_result)
				begin
					charge_sum_r   <= charge_sum_r + sext14(res_now);
					sample_tally_r <= sample_tally_r + 24'h000001;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ---- ccc_ctrl_sva.sv ----
// assertions for the coulomb counter control block
// sees only the top module ports; attached by the bind below
`timescale 1ns/100ps
`default_nettype none
`include "ccc_map.vh"
module ccc_ctrl_sva
#(
	parameter AW = 8
)
(
	// system
	input wire logic          clk,
	input wire logic          nrst,
	// bus
	input wire logic          wb_cyc_i,
	input wire logic          wb_stb_i,
	input wire logic          wb_we_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [3:0]    wb_sel_i,
	input wire logic [31:0]   wb_dat_i,
	input wire logic [31:0]   wb_dat_o,
	input wire logic          wb_ack_o,
	// converter and event
	input wire logic          conv_short_r,
	input wire logic          dither_active_r,
	input wire logic          calib_done_irq_r
);
// ----------------------------------------
// helpers
// ----------------------------------------
logic          tk;
logic          rd_r;
logic [AW-1:0] ra_r;
assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
always_ff @(posedge clk or negedge nrst)
begin
	if (!nrst)
		rd_r <= 1'b0;
	else
		rd_r <= tk && !wb_we_i;
end
always_ff @(posedge clk)
	ra_r <= wb_adr_i;
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);
sequence s_wc(b);
	tk && wb_we_i && wb_sel_i[0] && wb_adr_i == `CCC_CTRL_OFS && b;
endsequence
property p_irq_pulse;
	calib_done_irq_r |=> !calib_done_irq_r;
endproperty
a_irq_pulse: assert property (p_irq_pulse)
	else $error("calibration done pulse too long");
property p_irq_short;
	calib_done_irq_r |-> $past(conv_short_r) || $past(conv_short_r, 2);
endproperty
a_irq_short: assert property (p_irq_short)
	else $error("done pulse without shorted inputs");
property p_dset;
	s_wc(wb_dat_i[6]) |=> dither_active_r;
endproperty
a_dset: assert property (p_dset)
	else $error("dither set ignored");
property p_dclr;
	s_wc(wb_dat_i[7] && !wb_dat_i[6]) |=> !dither_active_r;
endproperty
a_dclr: assert property (p_dclr)
	else $error("dither clear ignored");
property p_wipe;
	s_wc(wb_dat_i[5] && !wb_dat_i[6] && !wb_dat_i[7])
		|=> $stable(dither_active_r);
endproperty
a_wipe: assert property (p_wipe)
	else $error("wipe changed dither state");
property p_dstat;
	wb_ack_o && rd_r && ra_r == `CCC_CTRL_OFS
		|-> wb_dat_o[`CCC_DACT_BIT] == $past(dither_active_r);
endproperty
a_dstat: assert property (p_dstat)
	else $error("dither status bit wrong");
property p_ofs_w;
	wb_ack_o && rd_r && ra_r == `CCC_OFFSET_OFS |-> wb_dat_o[31:10] == 22'h0;
endproperty
a_ofs_w: assert property (p_ofs_w)
	else $error("offset wider than ten bits");
property p_last_w;
	wb_ack_o && rd_r && ra_r == `CCC_LAST_OFS |-> wb_dat_o[31:14] == 18'h0;
endproperty
a_last_w: assert property (p_last_w)
	else $error("last result wider than fourteen bits");
endmodule
bind ccc_coulomb_ctrl ccc_ctrl_sva #(.AW(AW)) u_sva
(
	.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.conv_short_r(conv_short_r), .dither_active_r(dither_active_r),
	.calib_done_irq_r(calib_done_irq_r)
);
`default_nettype wire

// ---- ccc_map.vh ----
// register map, field positions, reset values and timing for the
// coulomb counter control block; definitions only
`ifndef CCC_MAP_VH
`define CCC_MAP_VH

// byte offsets on the wishbone bus
`define CCC_CTRL_OFS        8'h00
`define CCC_OFFSET_OFS      8'h04
`define CCC_TALLY_OFS       8'h08
`define CCC_SUM_OFS         8'h0C
`define CCC_LAST_OFS        8'h10

// control register fields
`define CCC_EN_BIT          0
`define CCC_PSEL_LO         1
`define CCC_PSEL_HI         2
`define CCC_HOLD_BIT        3
`define CCC_CALREQ_BIT      4
`define CCC_WIPE_BIT        5
`define CCC_DSET_BIT        6
`define CCC_DCLR_BIT        7
`define CCC_DACT_BIT        8
`define CCC_CALBUSY_BIT     9

// reset values
`define CCC_PSEL_RST        2'h0
`define CCC_ZERO32          32'h0000_0000

// converter clock in hertz and integration periods in microseconds
`define CCC_CONV_HZ         32768
`define CCC_PER0_US         250000
`define CCC_PER1_US         62500
`define CCC_PER2_US         15625
`define CCC_PER3_US         3906
`define CCC_US_TO_TICKS(us) (((us) * 4096 + 62500) / 125000)

// offset calibration averages this many periods
`define CCC_CAL_RUNS        8
`define CCC_CAL_SHIFT       3

`endif

// ---- testbench.sv ----
// self-checking bench for the coulomb counter control block
// wishbone master tasks plus a converter model on the analog side
`timescale 1ns/100ps
`default_nettype none
`include "ccc_map.vh"
module testbench;
logic        clk = 1'b0;
logic        nrst = 1'b0;
logic        cyc = 1'b0;
logic        stb = 1'b0;
logic        we = 1'b0;
logic [7:0]  adr = 8'h00;
logic [31:0] wd = 32'h0;
logic [31:0] rdat;
logic [31:0] rv;
logic [31:0] ofs;
logic        dact;
logic        ack;
logic        cclk;
logic        cbit;
logic        shrt;
logic        irq;
logic        lvl = 1'b1;
int          failures = 0;
int          tests_run = 0;
always #10 clk = ~clk;
ccc_coulomb_ctrl uut
(
	.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
	.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
	.wb_ack_o(ack), .conv_clk_pin(cclk), .conv_bit_pin(cbit),
	.conv_short_r(shrt), .dither_active_r(dact), .calib_done_irq_r(irq)
);
ccc_conv_model u_conv
(
	.short_en(shrt), .level(lvl), .conv_clk(cclk), .conv_bit(cbit)
);
// ----------------------------------------
// tasks
// ----------------------------------------
task wrap_up;
begin
	$display("checks %0d mismatches %0d", tests_run, failures);
	if (failures == 0 && tests_run > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
end
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
begin
	tests_run++;
	if (g !== e)
	begin
		failures++;
		$display("Error at %0t: got %h expected %h", $time, g, e);
	end
end
endtask
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	int k;
begin
	k = 0;
	@(posedge clk);
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= a;
	wd <= d;
	do
	begin
		@(posedge clk);
		k++;
	end
	while (ack !== 1'b1 && k < 20);
	rv = rdat;
	cyc <= 1'b0;
	stb <= 1'b0;
	if (ack !== 1'b1)
	begin
		failures++;
		wrap_up;
	end
end
endtask
task rdchk(input logic [7:0] a, input logic [31:0] e);
begin
	bus(1'b0, a, 32'h0);
	chk(rv, e);
end
endtask
task wait_tally(input logic [31:0] t);
	int k;
begin
	k = 0;
	do
	begin
		bus(1'b0, `CCC_TALLY_OFS, 32'h0);
		k++;
	end
	while (rv !== t && k < 6000);
	chk(rv, t);
	if (rv !== t)
		wrap_up;
end
endtask
// wipe once the first mixed period has landed, so later sums are exact
task fresh(input logic [31:0] c);
begin
	wait_tally(32'h1);
	bus(1'b1, `CCC_CTRL_OFS, c);
	rdchk(`CCC_TALLY_OFS, 32'h0);
	rdchk(`CCC_SUM_OFS, 32'h0);
end
endtask
// request calibration, see it run shorted, then wait for the done pulse
task calib(input logic [31:0] c, input logic [31:0] busy,
	input logic [31:0] idle);
	int k;
begin
	bus(1'b1, `CCC_CTRL_OFS, c);
	k = 0;
	while (shrt !== 1'b1 && k < 3000)
	begin
		@(posedge clk);
		k++;
	end
	chk({31'h0, shrt}, 32'h1);
	if (shrt !== 1'b1)
		wrap_up;
	rdchk(`CCC_CTRL_OFS, busy);
	k = 0;
	while (irq !== 1'b1 && k < 12000)
	begin
		@(posedge clk);
		k++;
	end
	chk({31'h0, irq}, 32'h1);
	if (irq !== 1'b1)
		wrap_up;
	rdchk(`CCC_CTRL_OFS, idle);
	rdchk(`CCC_OFFSET_OFS, 32'h40);
end
endtask
// ----------------------------------------
// tests
// ----------------------------------------
initial
begin
	repeat (3) @(posedge clk);
	nrst <= 1'b1;
	rdchk(`CCC_CTRL_OFS, 32'h0);
	for (int k = 0; k < 4; k++)
	begin
		bus(1'b1, `CCC_CTRL_OFS, 32'h8 | 32'(k << 1));
		rdchk(`CCC_CTRL_OFS, 32'h8 | 32'(k << 1));
	end
	$display("test done: period select");
	bus(1'b1, `CCC_CTRL_OFS, 32'h0F);
	calib(32'h1F, 32'h21F, 32'h0F);
	rdchk(`CCC_TALLY_OFS, 32'h0);
	$display("test done: calibration under hold");
	bus(1'b1, `CCC_CTRL_OFS, 32'h47);
	chk({31'h0, dact}, 32'h1);
	rdchk(`CCC_CTRL_OFS, 32'h107);
	fresh(32'h27);
	rdchk(`CCC_OFFSET_OFS, 32'h0);
	rdchk(`CCC_CTRL_OFS, 32'h107);
	wait_tally(32'h2);
	rdchk(`CCC_SUM_OFS, 32'h100);
	rdchk(`CCC_LAST_OFS, 32'h80);
	calib(32'h17, 32'h317, 32'h107);
	ofs = rv;
	wait_tally(32'h4);
	rdchk(`CCC_SUM_OFS, 32'h200);
	bus(1'b0, `CCC_LAST_OFS, 32'h0);
	chk(rv - ofs, 32'h40);
	$display("test done: charging, wipe, recalibration");
	lvl <= 1'b0;
	bus(1'b1, `CCC_CTRL_OFS, 32'h0F);
	bus(1'b1, `CCC_CTRL_OFS, 32'h2D);
	bus(1'b1, `CCC_CTRL_OFS, 32'h05);
	fresh(32'h25);
	wait_tally(32'h2);
	rdchk(`CCC_LAST_OFS, 32'h3E00);
	rdchk(`CCC_SUM_OFS, 32'hFFFFFC00);
	bus(1'b1, `CCC_CTRL_OFS, 32'h85);
	chk({31'h0, dact}, 32'h0);
	rdchk(`CCC_CTRL_OFS, 32'h05);
	// unmapped place reads zero
	rdchk(8'h14, 32'h0);
	$display("test done: discharge, period change, dither off");
	wrap_up;
end
endmodule
`default_nettype wire
